// [logic/tnr_defs.vh]
`ifndef TNR_DEFS_VH
`define TNR_DEFS_VH

// Fixed upper five bits of the target address byte
`define TNR_ADDR_FIXED 5'h18
// Bus direction bit value for write telegrams
`define TNR_RW_WRITE 1'h0

// Address-select pin level thresholds, pin level scaled so 8'hff is full supply
`define TNR_AS_LOW_MAX 8'h26
`define TNR_AS_MID2_MAX 8'h59
`define TNR_AS_MID1_MAX 8'hbf

// Leading bits that mark the control bytes
`define TNR_LEAD_AGCREF 2'h2
`define TNR_LEAD_PWRTEST 2'h3

// Field positions inside the control bytes
`define TNR_CB1_ATP_HI 5
`define TNR_CB1_ATP_LO 3
`define TNR_CB1_RS_HI 2
`define TNR_CB1_RS_LO 0
`define TNR_BB_CP_HI 7
`define TNR_BB_CP_LO 6
`define TNR_BB_SRC 5
`define TNR_BB_AUX 4
`define TNR_BB_BS_HI 3
`define TNR_BB_BS_LO 0
`define TNR_CB2_ATC 5
`define TNR_CB2_LOW_POWER_HOLD 4
`define TNR_CB2_T_HI 3
`define TNR_CB2_T_LO 0

// Reset values of the fields
`define TNR_RST_DIVIDER 15'h0000
`define TNR_RST_ATP 3'h3
`define TNR_RST_RS 3'h7
`define TNR_RST_CP 2'h3
`define TNR_RST_SRC 1'h0
`define TNR_RST_AUX 1'h0
`define TNR_RST_BS 4'h0
`define TNR_RST_ATC 1'h0
`define TNR_RST_LOW_POWER_HOLD 1'h0
`define TNR_RST_TEST 4'h2

// AGC start point table
`define TNR_ATP_DISABLED 3'h7
`define TNR_AGC_TOP_DBUV 7'h75
`define TNR_AGC_STEP_DBUV 7'h03
`define TNR_AGC_SHIFT_DBUV 7'h05

// Reference divider ratios
`define TNR_REF_24 8'h18
`define TNR_REF_28 8'h1c
`define TNR_REF_50 8'h32
`define TNR_REF_64 8'h40
`define TNR_REF_128 8'h80
`define TNR_REF_80 8'h50

// Charge pump currents in microamps
`define TNR_CP_70 10'h046
`define TNR_CP_140 10'h08c
`define TNR_CP_350 10'h15e
`define TNR_CP_600 10'h258

// Oscillator band codes
`define TNR_BAND_UHF 2'h0
`define TNR_BAND_VLO 2'h1
`define TNR_BAND_VHI 2'h2
`define TNR_BAND_RSV 2'h3

`endif

// [logic/tnr_addr_select.v]
`timescale 1ns/1ps
`include "tnr_defs.vh"

module tnr_addr_select (
  input wire mclk,
  input wire nrst,
  input wire [7:0] asLevel,
  input wire asOpen,
  output reg [1:0] addrSelectBits
);

  reg [7:0] levelMeta;
  reg [7:0] levelSync;
  reg openMeta;
  reg openSync;
  reg [1:0] next_addrSelectBits;

  // Pin level comes from outside the clock domain, two flops before use
  always @(posedge mclk) begin
    if (!nrst) begin
      levelMeta <= 8'h00;
      levelSync <= 8'h00;
      openMeta <= 1'h0;
      openSync <= 1'h0;
    end else begin
      levelMeta <= asLevel;
      levelSync <= levelMeta;
      openMeta <= asOpen;
      openSync <= openMeta;
    end
  end

  // Gaps between bands are split at their midpoints
  always @* begin
    if (openSync)
      next_addrSelectBits = 2'h1;
    else if (levelSync <= `TNR_AS_LOW_MAX)
      next_addrSelectBits = 2'h0;
    else if (levelSync <= `TNR_AS_MID2_MAX)
      next_addrSelectBits = 2'h1;
    else if (levelSync <= `TNR_AS_MID1_MAX)
      next_addrSelectBits = 2'h2;
    else
      next_addrSelectBits = 2'h3;
  end

  // Decoded bits are registered so the address compare sees a clean value
  always @(posedge mclk) begin
    if (!nrst)
      addrSelectBits <= 2'h0;
    else
      addrSelectBits <= next_addrSelectBits;
  end

endmodule // tnr_addr_select

// [logic/tnr_i2c_control.v]
// How it works
// - Address 11000, select bits, write bit zero.
// - Select bits come from address-select pin level.
// - Divider high byte, then low byte, MSB first.
// - Divider is plain binary, resets to zero.
// - Control byte 1: 10, start point, reference.
// - Band byte: pump, source, aux, band bits.
// - Control byte 2: 11, current, standby, test.
// - Start point picks threshold; 111 disables it.
// - Shift bit lowers every threshold by 5 dB.
// - Mixer source drops AGC in low VHF.
// - Reference select defaults to 111.
// - Codes 000-100 give 24,28,50,64,128.
// - Pump bits select 70/140/350/600 uA, default 11.
// - Detector source: zero IF amp, one mixer.
// - Aux bit zero means ADC input, one port on.
// - AGC current bit selects low or high current.
// - Standby stops mixer, oscillator and PLL.
// - Crystal buffer keeps running in standby.
// - Test bits reset to 0010.
// - Test bit 3 or 2 means test mode.
`timescale 1ns/1ps
`include "tnr_defs.vh"

module tnr_i2c_control (
  input wire mclk,
  input wire nrst,
  input wire scl,
  input wire sdaIn,
  output wire sdaOut,
  output reg sdaOe,
  input wire [7:0] asLevel,
  input wire asOpen,
  output reg [14:0] dividerRatio,
  output reg [2:0] agcStartPoint,
  output reg [2:0] refDivSelect,
  output reg [1:0] pumpCurrentSelect,
  output reg agcDetectorSource,
  output reg auxPortControl,
  output reg [3:0] bandSwitchBits,
  output reg agcCurrentSelect,
  output reg lowPowerHold,
  output reg [3:0] testBits,
  output reg [7:0] refDivRatio,
  output reg [9:0] pumpCurrentUa,
  output reg [6:0] agcThresholdDbuv,
  output reg agcEnable,
  output reg agcUndefined,
  output reg adcInputMode,
  output reg [1:0] oscBand,
  output reg mixerOscPllEnable,
  output reg crystalBufferEnable,
  output reg testMode
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RECV = 3'h1;
  localparam ST_ACKWAIT = 3'h2;
  localparam ST_ACK = 3'h3;
  localparam EXP_ANY = 2'h0;
  localparam EXP_DIVLO = 2'h1;
  localparam EXP_BAND = 2'h2;

  wire [1:0] addrSelectBits;
  reg [2:0] sclPipe;
  reg [2:0] sdaPipe;
  reg [2:0] state;
  reg [1:0] byteKind;
  reg [2:0] bitCnt;
  reg [6:0] shiftReg;
  reg isAddr;
  reg ackPend;
  wire sclS;
  wire sdaS;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;
  wire [7:0] fullByte;

  // Returns true when the address byte names this target for a write
  function addrMatch;
    input [7:0] b;
    input [1:0] sel;
    begin
      addrMatch = (b[7:3] == `TNR_ADDR_FIXED) && (b[2:1] == sel) &&
                  (b[0] == `TNR_RW_WRITE);
    end
  endfunction

  tnr_addr_select uAddrSel (
    .mclk(mclk),
    .nrst(nrst),
    .asLevel(asLevel),
    .asOpen(asOpen),
    .addrSelectBits(addrSelectBits)
  );

  // Bus pins and the link clock are asynchronous; bit 0 is only read by bit 1
  always @(posedge mclk) begin
    if (!nrst) begin
      sclPipe <= 3'h7;
      sdaPipe <= 3'h7;
    end else begin
      sclPipe <= {sclPipe[1:0], scl};
      sdaPipe <= {sdaPipe[1:0], sdaIn};
    end
  end

  assign sclS = sclPipe[1];
  assign sdaS = sdaPipe[1];
  assign sclRise = sclPipe[1] & ~sclPipe[2];
  assign sclFall = ~sclPipe[1] & sclPipe[2];
  // Start and stop need SCL high in both samples so a data change is not misread
  assign startSeen = sclS & sclPipe[2] & ~sdaS & sdaPipe[2];
  assign stopSeen = sclS & sclPipe[2] & sdaS & ~sdaPipe[2];
  assign fullByte = {shiftReg, sdaS};
  // Open-drain line: only ever pulled low
  assign sdaOut = 1'h0;

  // Target state machine, byte framing and acknowledge drive
  always @(posedge mclk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bitCnt <= 3'h0;
      shiftReg <= 7'h00;
      isAddr <= 1'h0;
      ackPend <= 1'h0;
      sdaOe <= 1'h0;
    end else if (startSeen) begin
      state <= ST_RECV;
      bitCnt <= 3'h0;
      isAddr <= 1'h1;
      ackPend <= 1'h0;
      sdaOe <= 1'h0;
    end else if (stopSeen) begin
      state <= ST_IDLE;
      sdaOe <= 1'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          sdaOe <= 1'h0;
        end
        ST_RECV: begin
          if (sclRise) begin
            shiftReg <= fullByte[6:0];
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == 3'h7) begin
              state <= ST_ACKWAIT;
              if (isAddr)
                ackPend <= addrMatch(fullByte, addrSelectBits);
              else
                ackPend <= 1'h1;
            end
          end
        end
        ST_ACKWAIT: begin
          if (sclFall) begin
            if (ackPend) begin
              sdaOe <= 1'h1;
              state <= ST_ACK;
            end else begin
              state <= ST_IDLE; // Not addressed: stay off the bus until next start
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'h0;
            bitCnt <= 3'h0;
            isAddr <= 1'h0;
            state <= ST_RECV;
          end
        end
        default: begin
          state <= ST_IDLE;
          sdaOe <= 1'h0;
        end
      endcase
    end
  end

  // Field commit happens on the eighth bit, so a cut-off byte changes nothing
  always @(posedge mclk) begin
    if (!nrst) begin
      byteKind <= EXP_ANY;
      dividerRatio <= `TNR_RST_DIVIDER;
      agcStartPoint <= `TNR_RST_ATP;
      refDivSelect <= `TNR_RST_RS;
      pumpCurrentSelect <= `TNR_RST_CP;
      agcDetectorSource <= `TNR_RST_SRC;
      auxPortControl <= `TNR_RST_AUX;
      bandSwitchBits <= `TNR_RST_BS;
      agcCurrentSelect <= `TNR_RST_ATC;
      lowPowerHold <= `TNR_RST_LOW_POWER_HOLD;
      testBits <= `TNR_RST_TEST;
    end else if (startSeen) begin
      byteKind <= EXP_ANY;
    end else if (state == ST_RECV && sclRise && bitCnt == 3'h7 && !isAddr) begin
      case (byteKind)
        EXP_DIVLO: begin
          dividerRatio[7:0] <= fullByte;
          byteKind <= EXP_ANY;
        end
        EXP_BAND: begin
          pumpCurrentSelect <= fullByte[`TNR_BB_CP_HI:`TNR_BB_CP_LO];
          agcDetectorSource <= fullByte[`TNR_BB_SRC];
          auxPortControl <= fullByte[`TNR_BB_AUX];
          bandSwitchBits <= fullByte[`TNR_BB_BS_HI:`TNR_BB_BS_LO];
          byteKind <= EXP_ANY;
        end
        default: begin
          if (!fullByte[7]) begin
            dividerRatio[14:8] <= fullByte[6:0];
            byteKind <= EXP_DIVLO;
          end else if (fullByte[7:6] == `TNR_LEAD_AGCREF) begin
            agcStartPoint <= fullByte[`TNR_CB1_ATP_HI:`TNR_CB1_ATP_LO];
            refDivSelect <= fullByte[`TNR_CB1_RS_HI:`TNR_CB1_RS_LO];
            byteKind <= EXP_BAND;
          end else begin
            agcCurrentSelect <= fullByte[`TNR_CB2_ATC];
            lowPowerHold <= fullByte[`TNR_CB2_LOW_POWER_HOLD];
            testBits <= fullByte[`TNR_CB2_T_HI:`TNR_CB2_T_LO];
            byteKind <= EXP_ANY;
          end
        end
      endcase
    end
  end

  reg [7:0] next_refDivRatio;
  reg [9:0] next_pumpCurrentUa;
  reg [1:0] next_oscBand;
  reg [6:0] next_agcThreshold;
  reg next_testMode;

  // Decode of the stored fields into analog setpoints
  always @* begin
    case (refDivSelect)
      3'h0: next_refDivRatio = `TNR_REF_24;
      3'h1: next_refDivRatio = `TNR_REF_28;
      3'h2: next_refDivRatio = `TNR_REF_50;
      3'h3: next_refDivRatio = `TNR_REF_64;
      3'h4: next_refDivRatio = `TNR_REF_128;
      default: next_refDivRatio = `TNR_REF_80; // Upper codes all give 80
    endcase
    case (pumpCurrentSelect)
      2'h0: next_pumpCurrentUa = `TNR_CP_70;
      2'h1: next_pumpCurrentUa = `TNR_CP_140;
      2'h2: next_pumpCurrentUa = `TNR_CP_350;
      default: next_pumpCurrentUa = `TNR_CP_600;
    endcase
    case (bandSwitchBits[1:0])
      2'h1: next_oscBand = `TNR_BAND_VLO;
      2'h2: next_oscBand = `TNR_BAND_VHI;
      2'h0: next_oscBand = `TNR_BAND_UHF;
      default: next_oscBand = `TNR_BAND_RSV;
    endcase
    // Three dB per code step, five dB lower with the shift bit
    next_agcThreshold = `TNR_AGC_TOP_DBUV
                        - (`TNR_AGC_STEP_DBUV * {4'h0, agcStartPoint});
    if (testBits[1])
      next_agcThreshold = next_agcThreshold - `TNR_AGC_SHIFT_DBUV;
    next_testMode = testBits[3] | testBits[2];
  end

  // Derived outputs lag the field registers by one clock
  always @(posedge mclk) begin
    if (!nrst) begin
      refDivRatio <= `TNR_REF_80;
      pumpCurrentUa <= `TNR_CP_600;
      oscBand <= `TNR_BAND_UHF;
      agcThresholdDbuv <= 7'h6c;
      agcEnable <= 1'h1;
      agcUndefined <= 1'h0;
      adcInputMode <= 1'h1;
      mixerOscPllEnable <= 1'h1;
      crystalBufferEnable <= 1'h1;
      testMode <= 1'h0;
    end else begin
      refDivRatio <= next_refDivRatio;
      pumpCurrentUa <= next_pumpCurrentUa;
      oscBand <= next_oscBand;
      agcThresholdDbuv <= next_agcThreshold;
      // AGC off for the disable code, in test mode, or mixer-fed in low VHF
      agcEnable <= (agcStartPoint != `TNR_ATP_DISABLED) && !next_testMode &&
                   !(agcDetectorSource && next_oscBand == `TNR_BAND_VLO);
      agcUndefined <= agcDetectorSource && next_oscBand == `TNR_BAND_VLO;
      adcInputMode <= ~auxPortControl;
      mixerOscPllEnable <= ~lowPowerHold;
      // Standby does not gate the crystal buffer; test mode and disable bit do
      crystalBufferEnable <= !next_testMode && !testBits[0];
      testMode <= next_testMode;
    end
  end

endmodule // tnr_i2c_control

// [dv/tnr_ctrl_properties.sv]
`timescale 1ns/1ps
module tnr_ctrl_properties (
  input wire mclk,
  input wire nrst,
  input wire scl,
  input wire sdaOut,
  input wire sdaOe,
  input wire lowPowerHold,
  input wire mixerOscPllEnable,
  input wire auxPortControl,
  input wire adcInputMode,
  input wire [3:0] testBits,
  input wire testMode,
  input wire crystalBufferEnable,
  input wire [2:0] refDivSelect,
  input wire [7:0] refDivRatio,
  input wire [1:0] pumpCurrentSelect,
  input wire [9:0] pumpCurrentUa,
  input wire [2:0] agcStartPoint,
  input wire agcEnable
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Decoded outputs follow their fields one clock later
  a_standby_stops: assert property (mixerOscPllEnable == !$past(lowPowerHold))
    else $error("mixer osc pll enable wrong");
  a_aux_adc_mode: assert property (adcInputMode == !$past(auxPortControl))
    else $error("adc input mode wrong");
  a_test_mode: assert property (testMode == (($past(testBits) & 4'hc) != 4'h0))
    else $error("test mode wrong");
  a_crystal_out: assert property (crystalBufferEnable == (($past(testBits) & 4'hd) == 4'h0))
    else $error("crystal buffer enable wrong");
  a_ref_ratio: assert property (refDivSelect == 3'h4 |=> refDivRatio == 8'h80)
    else $error("reference ratio wrong");
  a_pump_current: assert property (pumpCurrentSelect == 2'h3 |=> pumpCurrentUa == 10'h258)
    else $error("pump current wrong");
  a_agc_disable: assert property (agcStartPoint == 3'h7 |=> !agcEnable)
    else $error("agc not disabled");
  // Open drain: only ever pulls low, releases while SCL is low so no false stop
  a_sda_low_only: assert property (sdaOut == 1'b0 and ($fell(sdaOe) |-> !scl))
    else $error("sda drive value not low");
  a_ack_window: assert property ($rose(sdaOe) |-> !scl ##0 sdaOe[*4])
    else $error("acknowledge too short");
endmodule // tnr_ctrl_properties

bind tnr_i2c_control tnr_ctrl_properties u_props (.mclk(mclk), .nrst(nrst), .scl(scl),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .lowPowerHold(lowPowerHold),
  .mixerOscPllEnable(mixerOscPllEnable), .auxPortControl(auxPortControl),
  .adcInputMode(adcInputMode), .testBits(testBits), .testMode(testMode),
  .crystalBufferEnable(crystalBufferEnable), .refDivSelect(refDivSelect),
  .refDivRatio(refDivRatio), .pumpCurrentSelect(pumpCurrentSelect),
  .pumpCurrentUa(pumpCurrentUa), .agcStartPoint(agcStartPoint), .agcEnable(agcEnable));

// [dv/tnr_i2c_host.sv]
`timescale 1ns/1ps
module tnr_i2c_host (
  input wire mclk,
  input wire sdaOe,
  output reg scl,
  output reg sdaDrv
);
  // Pull-up on the line: released means high
  wire sdaLine = sdaDrv & ~sdaOe;

  // Bus idles high; clock only moves inside frames
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Four clocks per phase gives the 64 ns bus clock
  task automatic bitx(input logic b, output logic s);
    sdaDrv = b;
    tick(2);
    scl = 1'b1;
    tick(4);
    s = sdaLine;
    scl = 1'b0;
    tick(2);
  endtask

  task automatic start();
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sdaDrv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sdaDrv = 1'b1;
    tick(4);
  endtask

  // Fewer than eight bits means an aborted byte with no acknowledge clock
  task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
    logic s;
    for (int i = 7; i > 7 - n; i--) bitx(b[i], s);
    ack = 1'b0;
    if (n == 8) begin
      bitx(1'b1, s);
      ack = ~s;
    end
  endtask
endmodule // tnr_i2c_host

// [dv/tnr_testbench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic asOpen = 1'b1;
  logic [7:0] asLevel = 8'h00;
  int err_count = 0;
  int checked = 0;
  wire scl, sdaDrv, sdaOut, sdaOe;
  wire [14:0] dividerRatio;
  wire [2:0] agcStartPoint, refDivSelect;
  wire [1:0] pumpCurrentSelect, oscBand;
  wire [3:0] bandSwitchBits, testBits;
  wire [7:0] refDivRatio;
  wire [9:0] pumpCurrentUa;
  wire [6:0] agcThresholdDbuv;
  wire agcDetectorSource, auxPortControl, agcCurrentSelect, lowPowerHold, agcEnable;
  wire agcUndefined, adcInputMode, mixerOscPllEnable, crystalBufferEnable, testMode;
  // Wired-and of both parties on the data line
  wire sdaIn = sdaDrv & ~sdaOe;

  tnr_i2c_control dut (.mclk(mclk), .nrst(nrst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .asLevel(asLevel), .asOpen(asOpen), .dividerRatio(dividerRatio),
    .agcStartPoint(agcStartPoint), .refDivSelect(refDivSelect),
    .pumpCurrentSelect(pumpCurrentSelect), .agcDetectorSource(agcDetectorSource),
    .auxPortControl(auxPortControl), .bandSwitchBits(bandSwitchBits),
    .agcCurrentSelect(agcCurrentSelect), .lowPowerHold(lowPowerHold), .testBits(testBits),
    .refDivRatio(refDivRatio), .pumpCurrentUa(pumpCurrentUa),
    .agcThresholdDbuv(agcThresholdDbuv), .agcEnable(agcEnable), .agcUndefined(agcUndefined),
    .adcInputMode(adcInputMode), .oscBand(oscBand), .mixerOscPllEnable(mixerOscPllEnable),
    .crystalBufferEnable(crystalBufferEnable), .testMode(testMode));
  tnr_i2c_host h (.mclk(mclk), .sdaOe(sdaOe), .scl(scl), .sdaDrv(sdaDrv));

  // Clock at 125 MHz
  always #4 mclk = ~mclk;

  // Write telegram to select 01, every byte must be acknowledged
  task automatic frame(input logic [7:0] q[$]);
    logic a;
    h.start();
    h.wbyte(8'hc2, 8, a);
    `CHK(a, 1'b1)
    foreach (q[i]) begin
      h.wbyte(q[i], 8, a);
      `CHK(a, 1'b1)
    end
    h.stop();
    repeat (4) @(negedge mclk);
  endtask

  task t_reset;
    `CHK(dividerRatio, 15'h0000)
    `CHK(({agcStartPoint, refDivSelect, pumpCurrentSelect}), 8'h7f)
    `CHK(({agcDetectorSource, auxPortControl, bandSwitchBits, agcCurrentSelect}), 7'h00)
    `CHK(({lowPowerHold, testBits}), 5'h02)
    `CHK(({refDivRatio, pumpCurrentUa}), {8'h50, 10'h258})
    `CHK(agcThresholdDbuv, 7'h67)
    `CHK(({agcEnable, adcInputMode, oscBand, mixerOscPllEnable, crystalBufferEnable,
      testMode}), 7'h66)
    $display("t_reset done");
  endtask

  // Every pin level against every select code, then a read request
  task automatic t_addr;
    logic a;
    logic [7:0] lv[4] = '{8'h10, 8'h40, 8'h80, 8'hf0};
    asOpen = 1'b0;
    for (int l = 0; l < 4; l++) begin
      asLevel = lv[l];
      repeat (6) @(negedge mclk);
      for (int s = 0; s < 4; s++) begin
        h.start();
        h.wbyte({5'h18, s[1:0], 1'b0}, 8, a);
        h.stop();
        `CHK(a, (s == l))
      end
    end
    asOpen = 1'b1;
    asLevel = 8'h00;
    repeat (6) @(negedge mclk);
    h.start();
    h.wbyte(8'hc3, 8, a);
    h.stop();
    `CHK(a, 1'b0)
    $display("t_addr done");
  endtask

  task t_full;
    frame('{8'h2b, 8'hcd, 8'h83, 8'h71, 8'hf0});
    `CHK(dividerRatio, 15'h2bcd)
    `CHK(({agcStartPoint, refDivSelect}), 6'h03)
    `CHK(({pumpCurrentSelect, agcDetectorSource, auxPortControl, bandSwitchBits}), 8'h71)
    `CHK(({agcCurrentSelect, lowPowerHold, testBits}), 6'h30)
    `CHK(({refDivRatio, pumpCurrentUa, agcThresholdDbuv}), {8'h40, 10'h08c, 7'h75})
    `CHK(({agcUndefined, adcInputMode, oscBand, mixerOscPllEnable, crystalBufferEnable,
      testMode}), 7'h4a)
    $display("t_full done");
  endtask

  // All reference, pump, start point and band codes
  task automatic t_codes;
    logic [7:0] rt[8] = '{8'h18, 8'h1c, 8'h32, 8'h40, 8'h80, 8'h50, 8'h50, 8'h50};
    logic [9:0] pc[4] = '{10'h046, 10'h08c, 10'h15e, 10'h258};
    for (int i = 0; i < 8; i++) begin
      frame('{{2'b10, i[2:0], i[2:0]}, {i[1:0], 4'h0, i[1:0]}});
      `CHK(refDivRatio, rt[i])
      `CHK(pumpCurrentUa, pc[i % 4])
      `CHK(oscBand, i[1:0])
      `CHK(agcEnable, (i != 7))
      if (i < 7) `CHK(agcThresholdDbuv, 7'(117 - 3 * i))
    end
    frame('{8'h83, 8'h00, 8'hc2});
    `CHK(agcThresholdDbuv, 7'h70)
    $display("t_codes done");
  endtask

  task automatic t_test;
    logic [3:0] tv[4] = '{4'h8, 4'h4, 4'h1, 4'h0};
    for (int i = 0; i < 4; i++) begin
      frame('{{4'hc, tv[i]}});
      `CHK(testMode, (tv[i][3] | tv[i][2]))
      `CHK(crystalBufferEnable, (tv[i] == 4'h0))
    end
    $display("t_test done");
  endtask

  // Lone high divider byte, then a byte cut short by a stop
  task automatic t_partial;
    logic a;
    frame('{8'h11});
    `CHK(dividerRatio, 15'h11cd)
    h.start();
    h.wbyte(8'hc2, 8, a);
    h.wbyte(8'h2a, 4, a);
    h.stop();
    repeat (4) @(negedge mclk);
    `CHK(dividerRatio, 15'h11cd)
    $display("t_partial done");
  endtask

  task summarize;
    $display("Checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence after an eight cycle reset
  initial begin
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (12) @(negedge mclk);
    t_reset;
    t_addr;
    t_full;
    t_codes;
    t_test;
    t_partial;
    summarize;
  end

  // Watchdog well past the roughly 41 us the tests need
  initial begin
    #400000;
    err_count++;
    summarize;
  end
endmodule // testbench
